/* File: logic/lmac_top.sv */
// logger mission and alarm control register bank
// assumes: host link decoded elsewhere into byte register strobes and
// command pulses; conversions arrive as one-cycle result strobes
`timescale 1ns/1ps
`default_nettype none
module lmac_top #(
    parameter int LOG_BYTES = 8192, // log area size in bytes
    parameter int LOG_AW    = 13    // log address width
) (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_srst,
    // register port
    input  wire logic [15:0] i_addr,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_rdata,
    // command pulses
    input  wire logic        i_cmd_clear,
    input  wire logic        i_cmd_start,
    input  wire logic        i_cmd_stop,
    input  wire logic        i_cmd_force,
    // conversion results
    input  wire logic        i_conv_valid,
    input  wire logic        i_conv_forced,
    input  wire logic [15:0] i_conv_result,
    // log readback
    input  wire logic [LOG_AW-1:0] i_log_raddr,
    output logic      [7:0]  o_log_rdata,
    // status outputs
    output logic             o_osc_run,
    output logic             o_seconds_unit,
    output logic             o_conv_8bit,
    output logic             o_search_match,
    output logic [LOG_AW-1:0] o_log_ptr,
    output logic [23:0]      o_sample_count
);
    import lmac_pkg::*;

    // --------------------------------------------------------------------
    // state
    // --------------------------------------------------------------------
    logic [7:0]        low_thr_r,  low_thr_nxt;   // low threshold
    logic [7:0]        high_thr_r, high_thr_nxt;  // high threshold
    logic [7:0]        alarm_en_r, alarm_en_nxt;  // sensor_alarm_enable
    logic [7:0]        clk_ctrl_r, clk_ctrl_nxt;  // clock_control
    logic [7:0]        mission_r,  mission_nxt;   // mission_setup
    logic              high_flag_r, high_flag_nxt;
    logic              low_flag_r,  low_flag_nxt;
    logic              batt_r,      batt_nxt;     // battery_reset_flag
    logic              cleared_r,   cleared_nxt;  // log_cleared
    logic              wait_r,      wait_nxt;     // alarm_wait_pending
    lmac_state_t       state_r,     state_nxt;
    logic [LOG_AW-1:0] ptr_r,       ptr_nxt;      // next log byte
    logic [23:0]       count_r,     count_nxt;    // mission samples
    logic              lo_pend_r,   lo_pend_nxt;  // 16-bit low byte due
    logic [7:0]        lo_byte_r,   lo_byte_nxt;
    logic [7:0]        rdata_nxt;
    logic              low_hit;
    logic              high_hit;
    logic              mem_we;
    logic [7:0]        mem_wdata;
    logic              running;

    // --------------------------------------------------------------------
    // comparator and memory
    // --------------------------------------------------------------------
    lmac_alarm_cmp u_cmp (
        .i_result   (i_conv_result),
        .i_low_thr  (low_thr_r),
        .i_high_thr (high_thr_r),
        .i_low_en   (alarm_en_r[LMAC_BIT_LOW_EN]),
        .i_high_en  (alarm_en_r[LMAC_BIT_HIGH_EN]),
        .o_low_hit  (low_hit),
        .o_high_hit (high_hit)
    );

    lmac_log_mem #(
        .DEPTH (LOG_BYTES),
        .AW    (LOG_AW)
    ) u_mem (
        .i_clock (i_clock),
        .i_we    (mem_we),
        .i_waddr (ptr_r),
        .i_wdata (mem_wdata),
        .i_raddr (i_log_raddr),
        .o_rdata (o_log_rdata)
    );

    // --------------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------------
    // a write hits a register only when address matches
    function automatic logic wr_hit(input logic [15:0] a, input logic [15:0] r);
        return (a == r);
    endfunction : wr_hit

    assign running = (state_r != LMAC_IDLE);

    // --------------------------------------------------------------------
    // register and mission next-state logic
    // --------------------------------------------------------------------
    always_comb begin
        low_thr_nxt   = low_thr_r;
        high_thr_nxt  = high_thr_r;
        alarm_en_nxt  = alarm_en_r;
        clk_ctrl_nxt  = clk_ctrl_r;
        mission_nxt   = mission_r;
        high_flag_nxt = high_flag_r;
        low_flag_nxt  = low_flag_r;
        batt_nxt      = batt_r;
        cleared_nxt   = cleared_r;
        wait_nxt      = wait_r;
        state_nxt     = state_r;
        ptr_nxt       = ptr_r;
        count_nxt     = count_r;
        lo_pend_nxt   = 1'b0;
        lo_byte_nxt   = lo_byte_r;
        mem_we        = 1'b0;
        mem_wdata     = 8'h00;
        // host writes; locked set ignored while running
        if (i_wr && !running) begin
            if (wr_hit(i_addr, LMAC_ADDR_LOW_THR)) low_thr_nxt = i_wdata;
            if (wr_hit(i_addr, LMAC_ADDR_HIGH_THR)) high_thr_nxt = i_wdata;
            if (wr_hit(i_addr, LMAC_ADDR_ALARM_EN)) begin
                alarm_en_nxt = i_wdata & LMAC_CTRL_MASK;
            end
            if (wr_hit(i_addr, LMAC_ADDR_CLK_CTRL)) begin
                clk_ctrl_nxt = i_wdata & LMAC_CTRL_MASK;
            end
            if (wr_hit(i_addr, LMAC_ADDR_MISSION)) begin
                // bit 1 kept zero, bit 3 stored but unused
                mission_nxt = i_wdata & LMAC_MISS_MASK;
            end
        end
        // force or start wakes the oscillator
        if (i_cmd_force || (i_cmd_start && !running && cleared_r)) begin
            clk_ctrl_nxt[LMAC_BIT_OSC_RUN] = 1'b1;
        end
        // clear command: flags and counter reset, wait bit untouched
        if (i_cmd_clear && !running) begin
            high_flag_nxt = 1'b0;
            low_flag_nxt  = 1'b0;
            batt_nxt      = 1'b0;
            cleared_nxt   = 1'b1;
            count_nxt     = 24'h000000;
            ptr_nxt       = '0;
        end
        // mission sequencer
        case (state_r)
            LMAC_IDLE: begin
                // start only from a cleared log
                if (i_cmd_start && cleared_r) begin
                    cleared_nxt = 1'b0;
                    ptr_nxt     = '0;
                    if (mission_r[LMAC_BIT_ALM_START]) begin
                        state_nxt = LMAC_WAIT_ALARM;
                        wait_nxt  = 1'b1;
                    end else begin
                        state_nxt = LMAC_LOGGING;
                    end
                end
            end
            LMAC_WAIT_ALARM: begin
                // waiting conversions are not counted
                if (i_conv_valid && !i_conv_forced && (high_hit || low_hit)) begin
                    wait_nxt  = 1'b0;
                    state_nxt = LMAC_LOGGING;
                end
            end
            default: ;
        endcase
        // logging of a sample (the triggering one included)
        if (i_conv_valid && !i_conv_forced && mission_r[LMAC_BIT_LOG_EN] &&
            ((state_r == LMAC_LOGGING) ||
             (state_r == LMAC_WAIT_ALARM && (high_hit || low_hit)))) begin
            mem_we      = 1'b1;
            mem_wdata   = i_conv_result[15:8];
            ptr_nxt     = ptr_r + 1'b1;
            if (state_r == LMAC_LOGGING) count_nxt = count_r + 24'h000001;
            if (mission_r[LMAC_BIT_WIDTH_SEL]) begin
                lo_pend_nxt = 1'b1; // low byte follows at next address
                lo_byte_nxt = i_conv_result[7:0];
            end else if (ptr_r == LOG_AW'(LOG_BYTES - 1) && !mission_r[LMAC_BIT_WRAP]) begin
                state_nxt = LMAC_FULL;
            end
        end else if (lo_pend_r) begin
            mem_we    = 1'b1;
            mem_wdata = lo_byte_r;
            ptr_nxt   = ptr_r + 1'b1; // wraps to base
            if (ptr_r == LOG_AW'(LOG_BYTES - 1) && !mission_r[LMAC_BIT_WRAP]) begin
                state_nxt = LMAC_FULL;
            end
        end
        // alarm flags: mission conversions and forced ones
        if (i_conv_valid && (running || i_conv_forced)) begin
            if (high_hit) high_flag_nxt = 1'b1;
            if (low_hit)  low_flag_nxt  = 1'b1;
            if (i_conv_forced && high_hit) wait_nxt = 1'b0;
        end
        // stop ends any mission; wait bit left as is
        if (i_cmd_stop && running) state_nxt = LMAC_IDLE;
    end

    // --------------------------------------------------------------------
    // read mux
    // --------------------------------------------------------------------
    always_comb begin
        rdata_nxt = 8'h00;
        case (i_addr)
            LMAC_ADDR_LOW_THR:    rdata_nxt = low_thr_r;
            LMAC_ADDR_HIGH_THR:   rdata_nxt = high_thr_r;
            LMAC_ADDR_ALARM_EN:   rdata_nxt = alarm_en_r;
            LMAC_ADDR_CLK_CTRL:   rdata_nxt = clk_ctrl_r;
            LMAC_ADDR_MISSION:    rdata_nxt = mission_r | LMAC_MISS_ONES;
            LMAC_ADDR_ALARM_FLAG: rdata_nxt = LMAC_FLAG_ONES | {batt_r, 5'h00,
                                              high_flag_r, low_flag_r};
            LMAC_ADDR_STATE:      rdata_nxt = LMAC_STATE_ONES | {3'h0, wait_r,
                                              cleared_r, 1'b0, running, 1'b0};
            default:              rdata_nxt = 8'h00;
        endcase
    end

    // --------------------------------------------------------------------
    // registers
    // --------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            low_thr_r   <= LMAC_RST_BYTE;
            high_thr_r  <= LMAC_RST_BYTE;
            alarm_en_r  <= LMAC_RST_BYTE;
            clk_ctrl_r  <= LMAC_RST_BYTE;
            mission_r   <= LMAC_RST_BYTE;
            high_flag_r <= 1'b0;
            low_flag_r  <= 1'b0;
            batt_r      <= 1'b1; // power-on reset marks the battery flag
            cleared_r   <= 1'b0;
            wait_r      <= 1'b0;
            state_r     <= LMAC_IDLE;
            ptr_r       <= '0;
            count_r     <= 24'h000000;
            lo_pend_r   <= 1'b0;
            lo_byte_r   <= 8'h00;
            o_rdata     <= 8'h00;
        end else begin
            low_thr_r   <= low_thr_nxt;
            high_thr_r  <= high_thr_nxt;
            alarm_en_r  <= alarm_en_nxt;
            clk_ctrl_r  <= clk_ctrl_nxt;
            mission_r   <= mission_nxt;
            high_flag_r <= high_flag_nxt;
            low_flag_r  <= low_flag_nxt;
            batt_r      <= batt_nxt;
            cleared_r   <= cleared_nxt;
            wait_r      <= wait_nxt;
            state_r     <= state_nxt;
            ptr_r       <= ptr_nxt;
            count_r     <= count_nxt;
            lo_pend_r   <= lo_pend_nxt;
            lo_byte_r   <= lo_byte_nxt;
            o_rdata     <= i_rd ? rdata_nxt : o_rdata;
        end
    end

    // --------------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------------
    assign o_osc_run      = clk_ctrl_r[LMAC_BIT_OSC_RUN];
    assign o_seconds_unit = clk_ctrl_r[LMAC_BIT_HS_SAMP];
    // logging stops when full; 8-bit while waiting for alarm
    assign o_conv_8bit    = (state_r == LMAC_WAIT_ALARM);
    assign o_search_match = high_flag_r | low_flag_r | batt_r;
    assign o_log_ptr      = ptr_r;
    assign o_sample_count = count_r;

    // --------------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------------
    property p_lock_ctrl;
        @(posedge i_clock) disable iff (i_srst)
        (running && $past(running)) |-> $stable(clk_ctrl_r[LMAC_BIT_HS_SAMP]);
    endproperty
    a_lock_ctrl: assert property (p_lock_ctrl) else $error("clock control changed in mission");
    property p_high;
        @(posedge i_clock) disable iff (i_srst)
        (i_conv_valid && running && alarm_en_r[1] && i_conv_result[15:8] >= high_thr_r)
            |=> high_flag_r || $past(i_cmd_clear);
    endproperty
    a_high: assert property (p_high) else $error("high flag missed");
    property p_low;
        @(posedge i_clock) disable iff (i_srst)
        (i_conv_valid && running && alarm_en_r[0] && i_conv_result[15:8] <= low_thr_r)
            |=> low_flag_r || $past(i_cmd_clear);
    endproperty
    a_low: assert property (p_low) else $error("low flag missed");
    property p_start_osc;
        @(posedge i_clock) disable iff (i_srst)
        i_cmd_force |=> o_osc_run;
    endproperty
    a_start_osc: assert property (p_start_osc) else $error("oscillator not started");
    property p_miss_ones;
        @(posedge i_clock) disable iff (i_srst)
        (i_rd && i_addr == LMAC_ADDR_MISSION) |=> o_rdata[7:6] == 2'b11;
    endproperty
    a_miss_ones: assert property (p_miss_ones) else $error("mission setup top bits");
    property p_clear;
        @(posedge i_clock) disable iff (i_srst)
        (i_cmd_clear && !running && !i_conv_valid) |=> !high_flag_r && !low_flag_r && !batt_r;
    endproperty
    a_clear: assert property (p_clear) else $error("flags not cleared");
    property p_start_clr;
        @(posedge i_clock) disable iff (i_srst)
        (state_r == LMAC_IDLE && i_cmd_start && cleared_r && !i_cmd_clear)
            |=> running && !cleared_r;
    endproperty
    a_start_clr: assert property (p_start_clr) else $error("start did not run");
    property p_no_count_wait;
        @(posedge i_clock) disable iff (i_srst)
        (state_r == LMAC_WAIT_ALARM && !i_cmd_clear) |=> $stable(count_r);
    endproperty
    a_no_count_wait: assert property (p_no_count_wait) else $error("count moved in wait");
    property p_stop;
        @(posedge i_clock) disable iff (i_srst)
        (i_cmd_stop && running) |=> !running;
    endproperty
    a_stop: assert property (p_stop) else $error("stop ignored");
    c_start:  cover property (@(posedge i_clock) disable iff (i_srst) i_cmd_start && cleared_r);
    c_wait:   cover property (@(posedge i_clock) disable iff (i_srst)
                              state_r == LMAC_WAIT_ALARM ##1 state_r == LMAC_LOGGING);
    c_full:   cover property (@(posedge i_clock) disable iff (i_srst) state_r == LMAC_FULL);
endmodule : lmac_top
`default_nettype wire

/* File: logic/lmac_pkg.sv */
// package for the logger mission / alarm control register bank
// assumes: byte-wide register port, 16-bit register address, 40 MHz clock
package lmac_pkg;
    // --------------------------------------------------------------------
    // register offsets
    // --------------------------------------------------------------------
    localparam logic [15:0] LMAC_ADDR_LOW_THR    = 16'h0208; // low threshold
    localparam logic [15:0] LMAC_ADDR_HIGH_THR   = 16'h0209; // high threshold
    localparam logic [15:0] LMAC_ADDR_ALARM_EN   = 16'h0210; // sensor_alarm_enable
    localparam logic [15:0] LMAC_ADDR_CLK_CTRL   = 16'h0212; // clock_control
    localparam logic [15:0] LMAC_ADDR_MISSION    = 16'h0213; // mission_setup
    localparam logic [15:0] LMAC_ADDR_ALARM_FLAG = 16'h0214; // alarm_flags
    localparam logic [15:0] LMAC_ADDR_STATE      = 16'h0215; // mission_state
    localparam logic [15:0] LMAC_LOG_BASE        = 16'h1000; // log area base
    // --------------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------------
    localparam int LMAC_BIT_LOW_EN    = 0; // low_alarm_enable
    localparam int LMAC_BIT_HIGH_EN   = 1; // high_alarm_enable
    localparam int LMAC_BIT_OSC_RUN   = 0; // osc_run
    localparam int LMAC_BIT_HS_SAMP   = 1; // high_speed_sampling
    localparam int LMAC_BIT_LOG_EN    = 0; // logging_enable
    localparam int LMAC_BIT_WIDTH_SEL = 2; // log_width_select
    localparam int LMAC_BIT_WRAP      = 4; // wrap_enable
    localparam int LMAC_BIT_ALM_START = 5; // alarm_start_select
    localparam int LMAC_BIT_LOW_FLAG  = 0; // low_alarm_flag
    localparam int LMAC_BIT_HIGH_FLAG = 1; // high_alarm_flag
    localparam int LMAC_BIT_BATT      = 7; // battery_reset_flag
    localparam int LMAC_BIT_RUNNING   = 1; // mission_running
    localparam int LMAC_BIT_CLEARED   = 3; // log_cleared
    localparam int LMAC_BIT_WAIT      = 4; // alarm_wait_pending
    // --------------------------------------------------------------------
    // fixed bits and reset values
    // --------------------------------------------------------------------
    localparam logic [7:0] LMAC_CTRL_MASK   = 8'h03; // low two bits live
    localparam logic [7:0] LMAC_MISS_MASK   = 8'h3D; // bit 1 held zero
    localparam logic [7:0] LMAC_MISS_ONES   = 8'hC0; // bits 7,6 read one
    localparam logic [7:0] LMAC_FLAG_ONES   = 8'h70; // bits 6..4 read one
    localparam logic [7:0] LMAC_STATE_ONES  = 8'hC0; // bits 7,6 read one
    localparam logic [7:0] LMAC_RST_BYTE    = 8'h00; // control regs after reset
    localparam int         LMAC_LOG_BYTES   = 8192;  // log area size
    // --------------------------------------------------------------------
    // sequencer states
    // --------------------------------------------------------------------
    typedef enum logic [2:0] {
        LMAC_IDLE,
        LMAC_WAIT_ALARM,
        LMAC_LOGGING,
        LMAC_FULL
    } lmac_state_t;
endpackage : lmac_pkg

/* File: logic/lmac_alarm_cmp.sv */
// alarm threshold comparator for one conversion result
// assumes: result and thresholds stable while the caller's i_conv_valid is high
`timescale 1ns/1ps
`default_nettype none
module lmac_alarm_cmp (
    // conversion result
    input  wire logic [15:0] i_result,
    // thresholds and enables
    input  wire logic [7:0]  i_low_thr,
    input  wire logic [7:0]  i_high_thr,
    input  wire logic        i_low_en,
    input  wire logic        i_high_en,
    // alarm levels
    output logic             o_low_hit,
    output logic             o_high_hit
);
    // only the upper byte is compared, whatever the width mode
    always_comb begin
        o_high_hit = i_high_en && (i_result[15:8] >= i_high_thr);
        o_low_hit  = i_low_en  && (i_result[15:8] <= i_low_thr);
    end
endmodule : lmac_alarm_cmp
`default_nettype wire

/* File: logic/lmac_log_mem.sv */
// byte-wide log memory with registered read data
// assumes: single clock, one write and one read port
`timescale 1ns/1ps
`default_nettype none
module lmac_log_mem #(
    parameter int DEPTH = 8192,
    parameter int AW    = 13
) (
    // clock
    input  wire logic          i_clock,
    // write port
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [7:0]    i_wdata,
    // read port
    input  wire logic [AW-1:0] i_raddr,
    output logic      [7:0]    o_rdata
);
    logic [7:0] mem [DEPTH]; // storage array
    // write and registered read
    always_ff @(posedge i_clock) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule : lmac_log_mem
`default_nettype wire

/* File: test/lmac_hm.sv */
// host model: byte writes and reads on the register port of the bank
// assumes: the bank samples its port on the rising edge of i_clock
`timescale 1ns/1ps
`default_nettype none
module lmac_hm (
    // clock
    input  wire logic        i_clock,
    // register port
    output logic      [15:0] o_addr,
    output logic             o_wr,
    output logic             o_rd,
    output logic      [7:0]  o_wdata,
    input  wire logic [7:0]  i_rdata
);
    // idle port at time zero
    initial begin
        o_addr = 16'h0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
    end
    // one write; released lines flip so no stale value lingers
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(negedge i_clock);
        o_addr = a;
        o_wdata = (a == 16'h0213) ? (v & 8'hFD) : v;
        o_wr = 1'b1;
        @(negedge i_clock);
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~o_wdata;
    endtask : wr
    // one read; data stands one edge after the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(negedge i_clock);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_clock);
        v = i_rdata;
        o_rd = 1'b0;
        o_addr = ~a;
    endtask : rd
endmodule : lmac_hm
`default_nettype wire

/* File: test/tb_lmac_top.sv */
// bench for the logger register bank: register table, then two missions
// assumes: lmac_hm drives the register port, commands and results come from here
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
$display("unexpected %0t got %h exp %h", $time, (a), (e)); end end
module tb_lmac_top;
    logic        clock = 1'b0; // 40 MHz
    logic        srst = 1'b1;
    logic [15:0] addr, res = 16'h0000;
    logic [7:0]  wdata, rdata, lrdata, d;
    logic [3:0]  c = 4'h0; // clear, start, stop, force pulses
    logic        wr, rd, cv = 1'b0, cf = 1'b0, osc, sec, c8, sm;
    logic [2:0]  lra = 3'h0, ptr; // log cut to 8 bytes so it fills fast
    logic [23:0] cnt;
    int          num_errors = 0, n_checks = 0, cyc = 0;
    // address, byte written, byte read back
    logic [31:0] rows [8] = '{32'h0210FF03, 32'h0212FE02, 32'h021300C0, 32'h02133FFD,
        32'h021400F0, 32'h0215FFC0, 32'h02094040, 32'h02082020};
    logic [15:0] cvals [5] = '{16'h3000, 16'h4080, 16'h20FF, 16'h3100, 16'h3300};
    always #12.5 clock = ~clock;
    lmac_hm lmac_hm_inst (.i_clock(clock), .o_addr(addr), .o_wr(wr), .o_rd(rd),
        .o_wdata(wdata), .i_rdata(rdata));
    lmac_top #(.LOG_BYTES(8), .LOG_AW(3)) lmac_top_inst (.i_clock(clock), .i_srst(srst),
        .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata),
        .i_cmd_clear(c[0]), .i_cmd_start(c[1]), .i_cmd_stop(c[2]), .i_cmd_force(c[3]),
        .i_conv_valid(cv), .i_conv_forced(cf), .i_conv_result(res), .i_log_raddr(lra),
        .o_log_rdata(lrdata), .o_osc_run(osc), .o_seconds_unit(sec), .o_conv_8bit(c8),
        .o_search_match(sm), .o_log_ptr(ptr), .o_sample_count(cnt));
    // verdict and end of run
    task automatic results;
        if (num_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results
    // a hang counts as a mismatch
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            results();
        end
    end
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        lmac_hm_inst.rd(a, d);
        `CHK(d, e)
    endtask : rchk
    // log readback is registered, so wait two edges
    task automatic lchk(input logic [2:0] a, input logic [7:0] e);
        @(negedge clock);
        lra = a;
        repeat (2) @(negedge clock);
        `CHK(lrdata, e)
    endtask : lchk
    task automatic cmd(input int k);
        @(negedge clock);
        c[k] = 1'b1;
        @(negedge clock);
        c = 4'h0;
    endtask : cmd
    // idle cycle after each result keeps 16-bit writes apart
    task automatic conv(input logic [15:0] r, input logic f);
        @(negedge clock);
        res = r;
        cf = f;
        cv = 1'b1;
        @(negedge clock);
        cv = 1'b0;
        cf = 1'b0;
        res = ~r;
        @(negedge clock);
    endtask : conv
    initial begin
        repeat (20) @(negedge clock);
        srst = 1'b0;
        rchk(16'h0214, 8'hF0);
        rchk(16'h0215, 8'hC0);
        rchk(16'h0300, 8'h00);
        for (int i = 0; i < 8; i++) begin
            lmac_hm_inst.wr(rows[i][31:16], rows[i][15:8]);
            rchk(rows[i][31:16], rows[i][7:0]);
        end
        lmac_hm_inst.wr(16'h0212, 8'h03);
        `CHK({osc, sec}, 2'h3)
        lmac_hm_inst.wr(16'h0212, 8'h00);
        `CHK({osc, sec}, 2'h0)
        cmd(0);
        rchk(16'h0215, 8'hC8);
        rchk(16'h0214, 8'h70);
        lmac_hm_inst.wr(16'h0210, 8'h03);
        lmac_hm_inst.wr(16'h0213, 8'h15);
        cmd(1);
        rchk(16'h0215, 8'hC2);
        `CHK(osc, 1'b1)
        lmac_hm_inst.wr(16'h0210, 8'h00);
        rchk(16'h0210, 8'h03);
        lmac_hm_inst.wr(16'h0213, 8'h00);
        rchk(16'h0213, 8'hD5);
        for (int i = 0; i < 5; i++)
            conv(cvals[i], 1'b0);
        rchk(16'h0214, 8'h73);
        `CHK(cnt, 24'h000005)
        `CHK(ptr, 3'h2)
        `CHK(sm, 1'b1)
        lchk(3'h0, 8'h33);
        lchk(3'h2, 8'h40);
        lchk(3'h3, 8'h80);
        cmd(2);
        rchk(16'h0215, 8'hC0);
        cmd(1);
        rchk(16'h0215, 8'hC0);
        // forced conversion while idle
        cmd(0);
        lmac_hm_inst.wr(16'h0212, 8'h00);
        cmd(3);
        `CHK(osc, 1'b1)
        conv(16'h5000, 1'b1);
        rchk(16'h0214, 8'h72);
        // mission that waits for an alarm, no wrap
        cmd(0);
        lmac_hm_inst.wr(16'h0213, 8'h21);
        cmd(1);
        rchk(16'h0215, 8'hD2);
        `CHK(c8, 1'b1)
        conv(16'h3000, 1'b0);
        `CHK({cnt, ptr}, 27'h0)
        conv(16'h5000, 1'b0);
        rchk(16'h0215, 8'hC2);
        lchk(3'h0, 8'h50);
        for (int i = 0; i < 9; i++)
            conv(16'h3000, 1'b0);
        rchk(16'h0215, 8'hC2);
        lchk(3'h0, 8'h50);
        `CHK(cnt, 24'h000007)
        // mid-run reset puts the bank back to its power-on state
        @(negedge clock);
        srst = 1'b1;
        repeat (2) @(negedge clock);
        srst = 1'b0;
        rchk(16'h0214, 8'hF0);
        rchk(16'h0215, 8'hC0);
        `CHK({osc, cnt, ptr}, 28'h0)
        results();
    end
endmodule : tb_lmac_top
`default_nettype wire
